// ### design/cmbirq_regs.vh
// Register offsets, reset values and field limits of the mailbox interrupt block
`ifndef CMBIRQ_REGS_VH
`define CMBIRQ_REGS_VH
// ==========================================================
// Register byte offsets
`define CMBIRQ_ADDR_W 4
`define CMBIRQ_OFS_IRQ_ENABLE 4'h0
`define CMBIRQ_OFS_TX_FLAGS 4'h4
`define CMBIRQ_OFS_RX_FLAGS 4'h8
`define CMBIRQ_OFS_DIR 4'hC
// ==========================================================
// Reset values
`define CMBIRQ_RST_IRQ_ENABLE 32'h00000000
`define CMBIRQ_RST_TX_FLAGS 32'h00000000
`define CMBIRQ_RST_RX_FLAGS 32'h00000000
`define CMBIRQ_RST_DIR 32'h00000000
// ==========================================================
// Fields
`define CMBIRQ_TX_IMPL_MASK 32'h7FFFFFFF
`define CMBIRQ_RX_ONLY_BIT 31
`endif

// ### design/cmbirq_flag_bank.v
// Sticky per-mailbox completion flags with write-one-to-clear
`timescale 1ns/1ps
module cmbirq_flag_bank #(
  parameter WIDTH = 32,
  parameter [31:0] IMPL = 32'hFFFFFFFF,
  parameter [31:0] RST_VAL = 32'h00000000
) (
  input wire core_clk_i, // Core clock
  input wire rst_i, // Sync reset, high
  input wire [WIDTH-1:0] event_i, // Completion pulses
  input wire [WIDTH-1:0] enable_i, // Per-mailbox enable
  input wire clr_wr_i, // Clear write strobe
  input wire [WIDTH-1:0] clr_data_i, // Ones clear
  output wire [WIDTH-1:0] flags_o, // Flag state
  output wire any_o // OR of flags
);
  reg [WIDTH-1:0] flags_reg;
  reg [WIDTH-1:0] flags_next;
  wire [WIDTH-1:0] impl_w;
  wire [WIDTH-1:0] clr_w;

  assign impl_w = IMPL[WIDTH-1:0];
  assign clr_w = clr_wr_i ? clr_data_i : {WIDTH{1'b0}};

  // ==========================================================
  // Next state
  always @* begin
    flags_next = ((flags_reg & ~clr_w) | (event_i & enable_i)) & impl_w;
  end

  always @(posedge core_clk_i) begin
    if (rst_i) begin
      flags_reg <= RST_VAL[WIDTH-1:0];
    end else begin
      flags_reg <= flags_next;
    end
  end

  assign flags_o = flags_reg;
  assign any_o = |flags_reg;
endmodule // cmbirq_flag_bank

// ### design/cmbirq_edge_pulse.v
// Rising-edge pulse generator for an interrupt level
`timescale 1ns/1ps
module cmbirq_edge_pulse (
  input wire core_clk_i, // Core clock
  input wire rst_i, // Sync reset, high
  input wire level_i, // Interrupt level
  output reg pulse_o // One-cycle pulse
);
  reg level_reg;

  always @(posedge core_clk_i) begin
    if (rst_i) begin
      level_reg <= 1'b0;
      pulse_o <= 1'b0;
    end else begin
      level_reg <= level_i;
      pulse_o <= level_i & ~level_reg;
    end
  end
endmodule // cmbirq_edge_pulse

// ### design/cmbirq_top.v
// Mailbox interrupt mask, completion flags and interrupt lines
`timescale 1ns/1ps
`include "cmbirq_regs.vh"
// Functional notes
// - Mask bit one enables mailbox interrupts
// - Mask register resets to all zeros
// - Transmit flags 30..0 map mailboxes 30..0
// - Transmit bit 31 reads zero, ignores writes
// - Enabled transmit completion sets flag, raises line
// - Disabled transmit completion sets nothing
// - Transmit line high while any flag set
// - Write one clears transmit flag
// - Receive mailbox reads zero in transmit flags
// - Transmit mailbox reads zero in receive flags
// - Enabled receive completion sets receive flag
// - Receive line: OR of flags, W1C
// - Request pulses on rising level edges
module cmbirq_top #(
  parameter MBOX_N = 32
) (
  input wire core_clk_i, // Core clock, 10 MHz
  input wire rst_i, // Sync reset, high
  input wire [`CMBIRQ_ADDR_W-1:0] reg_addr_i, // Register byte address
  input wire [31:0] reg_wdata_i, // Write data
  input wire reg_wr_i, // Write strobe
  input wire reg_rd_i, // Read strobe
  output reg [31:0] reg_rdata_o, // Read data, next cycle
  input wire [MBOX_N-1:0] tx_done_i, // Transmit success pulses
  input wire [MBOX_N-1:0] rx_done_i, // Receive success pulses
  output reg tx_done_irq_o, // Transmit completion level
  output reg rx_done_irq_o, // Receive completion level
  output wire tx_done_req_o, // Transmit request pulse
  output wire rx_done_req_o, // Receive request pulse
  output reg [MBOX_N-1:0] mbox_is_tx_o // Mailbox direction, 1=tx
);
  reg [MBOX_N-1:0] mailbox_irq_enable_reg;
  reg [MBOX_N-1:0] mbox_dir_reg;
  wire [MBOX_N-1:0] tx_flags_w;
  wire [MBOX_N-1:0] rx_flags_w;
  wire tx_any_w;
  wire rx_any_w;
  reg [31:0] rdata_next;

  function sel;
    input [`CMBIRQ_ADDR_W-1:0] addr;
    input [`CMBIRQ_ADDR_W-1:0] ofs;
    begin
      sel = (addr == ofs);
    end
  endfunction

  // ==========================================================
  // Writable registers
  always @(posedge core_clk_i) begin
    if (rst_i) begin
      mailbox_irq_enable_reg <= `CMBIRQ_RST_IRQ_ENABLE;
      mbox_dir_reg <= `CMBIRQ_RST_DIR;
    end else if (reg_wr_i) begin
      if (sel(reg_addr_i, `CMBIRQ_OFS_IRQ_ENABLE)) begin
        mailbox_irq_enable_reg <= reg_wdata_i[MBOX_N-1:0];
      end
      if (sel(reg_addr_i, `CMBIRQ_OFS_DIR)) begin
        // Mailbox 31 can never transmit
        mbox_dir_reg <= reg_wdata_i[MBOX_N-1:0] & `CMBIRQ_TX_IMPL_MASK;
      end
    end
  end

  // ==========================================================
  // Flag banks
  // transmit flags, mask gated
  cmbirq_flag_bank #(
    .WIDTH(MBOX_N),
    .IMPL(`CMBIRQ_TX_IMPL_MASK),
    .RST_VAL(`CMBIRQ_RST_TX_FLAGS)
  ) u_tx_flags (
    .core_clk_i(core_clk_i),
    .rst_i(rst_i),
    .event_i(tx_done_i),
    .enable_i(mailbox_irq_enable_reg),
    .clr_wr_i(reg_wr_i & sel(reg_addr_i, `CMBIRQ_OFS_TX_FLAGS)),
    .clr_data_i(reg_wdata_i),
    .flags_o(tx_flags_w),
    .any_o(tx_any_w)
  );

  cmbirq_flag_bank #(
    .WIDTH(MBOX_N),
    .IMPL(32'hFFFFFFFF),
    .RST_VAL(`CMBIRQ_RST_RX_FLAGS)
  ) u_rx_flags (
    .core_clk_i(core_clk_i),
    .rst_i(rst_i),
    .event_i(rx_done_i),
    .enable_i(mailbox_irq_enable_reg),
    .clr_wr_i(reg_wr_i & sel(reg_addr_i, `CMBIRQ_OFS_RX_FLAGS)),
    .clr_data_i(reg_wdata_i),
    .flags_o(rx_flags_w),
    .any_o(rx_any_w)
  );

  // ==========================================================
  // Interrupt levels and request pulses
  // Levels registered one cycle after the flags for clean outputs
  always @(posedge core_clk_i) begin
    if (rst_i) begin
      tx_done_irq_o <= 1'b0;
      rx_done_irq_o <= 1'b0;
      mbox_is_tx_o <= `CMBIRQ_RST_DIR;
    end else begin
      tx_done_irq_o <= tx_any_w;
      rx_done_irq_o <= rx_any_w;
      mbox_is_tx_o <= mbox_dir_reg;
    end
  end

  cmbirq_edge_pulse u_tx_pulse (
    .core_clk_i(core_clk_i),
    .rst_i(rst_i),
    .level_i(tx_any_w),
    .pulse_o(tx_done_req_o)
  );

  cmbirq_edge_pulse u_rx_pulse (
    .core_clk_i(core_clk_i),
    .rst_i(rst_i),
    .level_i(rx_any_w),
    .pulse_o(rx_done_req_o)
  );

  // ==========================================================
  // Read path
  always @* begin
    rdata_next = 32'h00000000;
    if (sel(reg_addr_i, `CMBIRQ_OFS_IRQ_ENABLE)) begin
      rdata_next = mailbox_irq_enable_reg;
    end else if (sel(reg_addr_i, `CMBIRQ_OFS_TX_FLAGS)) begin
      rdata_next = tx_flags_w & mbox_dir_reg & `CMBIRQ_TX_IMPL_MASK;
    end else if (sel(reg_addr_i, `CMBIRQ_OFS_RX_FLAGS)) begin
      rdata_next = rx_flags_w & ~mbox_dir_reg;
    end else if (sel(reg_addr_i, `CMBIRQ_OFS_DIR)) begin
      rdata_next = mbox_dir_reg;
    end
  end

  always @(posedge core_clk_i) begin
    if (rst_i) begin
      reg_rdata_o <= 32'h00000000;
    end else if (reg_rd_i) begin
      reg_rdata_o <= rdata_next;
    end else begin
      reg_rdata_o <= 32'h00000000;
    end
  end
endmodule // cmbirq_top

// ### tb/cmbirq_top_properties.sv
// Checker for the mailbox interrupt block ports
`timescale 1ns/1ps
module cmbirq_top_properties (
  input wire core_clk_i, // Clock
  input wire rst_i, // Reset
  input wire [3:0] reg_addr_i, // Addr
  input wire [31:0] reg_wdata_i, // Wdata
  input wire reg_wr_i, // Write
  input wire reg_rd_i, // Read
  input wire [31:0] reg_rdata_o, // Rdata
  input wire [31:0] tx_done_i, // Tx events
  input wire [31:0] rx_done_i, // Rx events
  input wire tx_done_irq_o, // Tx level
  input wire rx_done_irq_o, // Rx level
  input wire tx_done_req_o, // Tx pulse
  input wire rx_done_req_o, // Rx pulse
  input wire [31:0] mbox_is_tx_o // Direction
);
  // Shadow of the mask, updated at the same edge as the design
  reg [31:0] en_reg;
  always @(posedge core_clk_i) begin
    if (rst_i) en_reg <= 32'h0;
    else if (reg_wr_i && reg_addr_i == 4'h0) en_reg <= reg_wdata_i;
  end
  // Direction shadow; the port copy lags a cycle, so back-to-back write/read needs this
  reg [31:0] dir_reg;
  always @(posedge core_clk_i) begin
    if (rst_i) dir_reg <= 32'h0;
    else if (reg_wr_i && reg_addr_i == 4'hC) dir_reg <= reg_wdata_i & 32'h7FFFFFFF;
  end
  default clocking @(posedge core_clk_i); endclocking
  default disable iff (rst_i);
  sequence tx_hit; (tx_done_i & en_reg & 32'h7FFFFFFF) != 32'h0; endsequence
  sequence rx_hit; (rx_done_i & en_reg) != 32'h0; endsequence
  sequence tx_rd; $past(reg_rd_i && reg_addr_i == 4'h4); endsequence
  sequence rx_rd; $past(reg_rd_i && reg_addr_i == 4'h8); endsequence
  chk_tx_sets_irq: assert property (tx_hit |-> ##2 tx_done_irq_o) else $error("tx irq missing");
  chk_rx_sets_irq: assert property (rx_hit |-> ##2 rx_done_irq_o) else $error("rx irq missing");
  chk_tx_req_edge: assert property (tx_done_req_o == $rose(tx_done_irq_o)) else $error("tx req bad");
  chk_rx_req_edge: assert property (rx_done_req_o == $rose(rx_done_irq_o)) else $error("rx req bad");
  chk_reset_clears: assert property (disable iff (1'b0) rst_i |=> !tx_done_irq_o && !rx_done_irq_o)
    else $error("reset left irq");
  chk_tx_bit31_zero: assert property (tx_rd |-> !reg_rdata_o[31]) else $error("tx bit31 set");
  chk_rx_box_hidden: assert property (tx_rd |-> (reg_rdata_o & ~$past(dir_reg)) == 32'h0)
    else $error("rx box in tx flags");
  chk_tx_box_hidden: assert property (rx_rd |-> (reg_rdata_o & $past(dir_reg)) == 32'h0)
    else $error("tx box in rx flags");
endmodule // cmbirq_top_properties
bind cmbirq_top cmbirq_top_properties chk (.core_clk_i(core_clk_i), .rst_i(rst_i), .reg_addr_i(reg_addr_i),
  .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o),
  .tx_done_i(tx_done_i), .rx_done_i(rx_done_i), .tx_done_irq_o(tx_done_irq_o), .rx_done_irq_o(rx_done_irq_o),
  .tx_done_req_o(tx_done_req_o), .rx_done_req_o(rx_done_req_o), .mbox_is_tx_o(mbox_is_tx_o));

// ### tb/cmbirq_intc_model.sv
// Interrupt controller model counting request pulses
`timescale 1ns/1ps
module cmbirq_intc_model (
  input wire core_clk_i, // Clock
  input wire rst_i, // Reset
  input wire tx_req_i, // Tx pulse
  input wire rx_req_i, // Rx pulse
  output reg [31:0] tx_cnt_o, // Tx count
  output reg [31:0] rx_cnt_o // Rx count
);
  always @(posedge core_clk_i) begin
    if (rst_i) begin
      tx_cnt_o <= 32'h0;
      rx_cnt_o <= 32'h0;
    end else begin
      tx_cnt_o <= tx_cnt_o + tx_req_i;
      rx_cnt_o <= rx_cnt_o + rx_req_i;
    end
  end
endmodule // cmbirq_intc_model

// ### tb/cmbirq_tb_top.sv
// Register and event test of the mailbox interrupt block
`timescale 1ns/1ps
module cmbirq_tb_top;
  reg clk = 1'b0, rst = 1'b1, wr = 1'b0, rd = 1'b0;
  reg [3:0] addr = 4'h0;
  reg [31:0] wd = 32'h0, tx = 32'h0, rx = 32'h0;
  wire [31:0] rdata, dir, txc, rxc;
  wire txi, rxi, txq, rxq;
  integer miscompares = 0, compares = 0, i;
  always #50 clk = ~clk;
  cmbirq_top dut (.core_clk_i(clk), .rst_i(rst), .reg_addr_i(addr), .reg_wdata_i(wd), .reg_wr_i(wr),
    .reg_rd_i(rd), .reg_rdata_o(rdata), .tx_done_i(tx), .rx_done_i(rx), .tx_done_irq_o(txi),
    .rx_done_irq_o(rxi), .tx_done_req_o(txq), .rx_done_req_o(rxq), .mbox_is_tx_o(dir));
  cmbirq_intc_model intc (.core_clk_i(clk), .rst_i(rst), .tx_req_i(txq), .rx_req_i(rxq),
    .tx_cnt_o(txc), .rx_cnt_o(rxc));
  // ==========================================
  // Bus tasks
  task chk(input [31:0] g, input [31:0] e);
    compares = compares + 1;
    if (g !== e) begin
      miscompares = miscompares + 1;
      $display("mismatch %0t got %h exp %h", $time, g, e);
    end
  endtask
  task wrt(input [3:0] a, input [31:0] d);
    @(posedge clk); wr <= 1'b1; addr <= a; wd <= d;
    @(posedge clk); wr <= 1'b0;
  endtask
  task rdc(input [3:0] a, input [31:0] e);
    @(posedge clk); rd <= 1'b1; addr <= a;
    @(posedge clk); rd <= 1'b0;
    #1 chk(rdata, e);
  endtask
  task ev(input [31:0] t, input [31:0] r);
    @(posedge clk); tx <= t; rx <= r;
    @(posedge clk); tx <= 32'h0; rx <= 32'h0;
  endtask
  task close_out;
    if (miscompares == 0 && compares > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  // ==========================================
  // Tests
  initial begin
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    for (i = 0; i < 5; i = i + 1) rdc(i == 4 ? 4'h2 : 4 * i, 32'h0);
    wrt(4'hC, 32'hFFFFFFFF); rdc(4'hC, 32'h7FFFFFFF);
    chk(dir, 32'h7FFFFFFF);
    ev(32'h1, 32'h0); rdc(4'h4, 32'h0); chk(txi, 0);
    wrt(4'h0, 32'hFFFFFFFF); rdc(4'h0, 32'hFFFFFFFF);
    ev(32'hFFFFFFFF, 32'h0); rdc(4'h4, 32'h7FFFFFFF);
    chk(txi, 1); chk(txc, 1);
    wrt(4'h4, 32'hFFFFFFFE); rdc(4'h4, 32'h1);
    @(posedge clk); wr <= 1'b1; addr <= 4'h4; wd <= 32'h1; tx <= 32'h1;
    @(posedge clk); wr <= 1'b0; tx <= 32'h0;
    rdc(4'h4, 32'h1);
    wrt(4'h4, 32'h1); rdc(4'h4, 32'h0); chk(txi, 0);
    ev(32'h0, 32'hFFFFFFFF); rdc(4'h8, 32'h80000000); chk(rxi, 1); chk(rxc, 1);
    wrt(4'hC, 32'h0); rdc(4'h8, 32'hFFFFFFFF);
    ev(32'h20, 32'h0); rdc(4'h4, 32'h0); chk(txi, 1); chk(txc, 2);
    wrt(4'h8, 32'hFFFFFFFF); wrt(4'h0, 32'h0); ev(32'h0, 32'h1);
    rdc(4'h8, 32'h0); chk(rxi, 0);
    chk(rxc, 1);
    close_out;
  end
  // Run needs about 60 cycles
  initial begin
    #100000;
    miscompares = miscompares + 1;
    close_out;
  end
endmodule // cmbirq_tb_top
